// >>> rtl/dps_top.sv
// Notes on behaviour
// - Shift one data bit into the 23-bit register per serial clock rise.
// - While load strobe is high, copy the word into the addressed latch.
// - Control field picks IF ref, IF prog, RF ref or RF prog latch.
// - Lock output select high gives phase monitor, low gives lock detect.
// - Each section power-save input: high runs, low stops that section.
// - Phase polarity bit swaps the phase detector up and down outputs.
// - Losing a section's supply clears that section's latched divider data.
// - Reference divider is 14 bits; host loads 5 to 16383.
// - Swallow counter is 7 bits; host loads 0 to 127.
// - Main counter is 11 bits; host loads 5 to 2047.
// - RF prescaler selectable between 64/65 and 128/129.
// - IF prescaler selectable between 16/17 and 32/33.
// - Feedback divides by P times N plus A; host keeps A below N.
// - Only data, clock and load strobe pins program four independent latches.
`timescale 1ns/1ps
`default_nettype none

module dps_section #(
    parameter logic [7:0] BASE_LO = 8'h10,
    parameter logic [7:0] BASE_HI = 8'h20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic run,
    input wire logic ref_edge,
    input wire logic fin_edge,
    input wire logic [13:0] ref_div,
    input wire logic [6:0] swal_cnt,
    input wire logic [10:0] main_cnt,
    input wire logic mod_sel,
    input wire logic polarity,
    // Results
    output logic pd_up,
    output logic pd_down,
    output logic locked,
    output logic ref_tick,
    output logic modulus_ctrl
);
    import dps_pkg::*;

    logic [13:0] ref_left;
    logic [7:0] pre_left;
    logic [6:0] swal_left;
    logic [10:0] main_left;
    logic fb_tick;
    logic [2:0] lock_run;

    // ==============================
    // Dividers
    // modulus choice
    wire logic [7:0] base = mod_sel ? BASE_HI : BASE_LO;
    // swallow phase uses the upper modulus
    wire logic swallowing = (swal_left != 7'h00);
    // Reload value for the next prescaler cycle: the upper modulus only while swallows remain
    wire logic swallow_next = (swal_left > 7'h01);
    wire logic [7:0] modulus = swallow_next ? base + 8'h01 : base;
    wire logic pre_out = fin_edge && (pre_left <= 8'h01);
    wire logic ref_out = ref_edge && (ref_left <= 14'h0001);
    // total feedback = P*N + A
    wire logic main_out = pre_out && (main_left <= 11'h001);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ref_left <= 14'h0000;
            pre_left <= 8'h00;
            swal_left <= 7'h00;
            main_left <= 11'h000;
            ref_tick <= 1'b0;
            fb_tick <= 1'b0;
        end else if (!run) begin
            ref_left <= ref_div;
            pre_left <= base + {7'h00, swal_cnt != 7'h00};
            swal_left <= swal_cnt;
            main_left <= main_cnt;
            ref_tick <= 1'b0;
            fb_tick <= 1'b0;
        end else begin
            ref_tick <= ref_out;
            fb_tick <= main_out;
            if (ref_edge) begin
                ref_left <= ref_out ? ref_div : ref_left - 14'h0001;
            end
            if (fin_edge) begin
                pre_left <= pre_out ? modulus : pre_left - 8'h01;
            end
            // count down, reload swallow, main and prescaler on main expiry
            if (main_out) begin
                swal_left <= swal_cnt;
                main_left <= main_cnt;
                pre_left <= base + {7'h00, swal_cnt != 7'h00};
            end else if (pre_out) begin
                swal_left <= swallowing ? swal_left - 7'h01 : swal_left;
                main_left <= main_left - 11'h001;
            end
        end
    end

    // ==============================
    // Phase detector and lock detect
    // Tri-state style detector: whichever tick leads holds its side until the other arrives
    logic lead_ref;
    logic lead_fb;
    wire logic both = (lead_ref || ref_tick) && (lead_fb || fb_tick);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lead_ref <= 1'b0;
            lead_fb <= 1'b0;
            pd_up <= 1'b0;
            pd_down <= 1'b0;
            lock_run <= 3'h0;
            locked <= 1'b0;
            modulus_ctrl <= 1'b0;
        end else begin
            lead_ref <= run && !both && (lead_ref || ref_tick);
            lead_fb <= run && !both && (lead_fb || fb_tick);
            pd_up <= run && !both && (polarity ? (lead_fb || fb_tick) : (lead_ref || ref_tick));
            pd_down <= run && !both && (polarity ? (lead_ref || ref_tick) : (lead_fb || fb_tick));
            // Lock after several reference periods with no reference tick leading the feedback tick
            if (!run || (ref_tick && !both)) begin
                lock_run <= 3'h0;
            end else if (ref_tick && lock_run != LOCK_HOLD_CNT) begin
                lock_run <= lock_run + 3'h1;
            end
            locked <= run && (lock_run == LOCK_HOLD_CNT);
            modulus_ctrl <= run && swallowing;
        end
    end
endmodule // dps_section

module dps_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Serial programming pins
    input wire logic serial_data,
    input wire logic serial_clock,
    input wire logic load_strobe,
    // Section controls and supplies
    input wire logic if_power_save_n,
    input wire logic rf_power_save_n,
    input wire logic if_supply_ok,
    input wire logic rf_supply_ok,
    // Divider inputs
    input wire logic ref_osc_in,
    input wire logic if_prescaler_in,
    input wire logic rf_prescaler_in,
    // Outputs
    output logic lock_or_monitor_out,
    output logic if_pump_up,
    output logic if_pump_down,
    output logic rf_pump_up,
    output logic rf_pump_down,
    output logic if_modulus_ctrl,
    output logic rf_modulus_ctrl
);
    import dps_pkg::*;

    // ==============================
    // Pin synchronisers
    wire logic [dps_pkg::SYNC_W-1:0] pins = {rf_prescaler_in, if_prescaler_in, ref_osc_in,
        rf_supply_ok, if_supply_ok, rf_power_save_n, if_power_save_n,
        load_strobe, serial_clock, serial_data};
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [SYNC_W-1:0] sync_c;
    logic [SYNC_W-1:0] clean;
    logic [SYNC_W-1:0] rise;

    // A change is accepted only when the second and third stages agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
            clean <= '0;
        end else begin
            sync_a <= pins;
            sync_b <= sync_a;
            sync_c <= sync_b;
            clean <= (sync_b & sync_c) | (clean & (sync_b | sync_c));
        end
    end

    wire logic [SYNC_W-1:0] next_clean = (sync_b & sync_c) | (clean & (sync_b | sync_c));
    assign rise = next_clean & ~clean;

    wire logic sdata = clean[0];
    wire logic sclk_rise = rise[1];
    wire logic strobe = clean[2];
    // power-save inputs, assumed driven low at power-on
    wire logic if_run = clean[3] && clean[5];
    wire logic rf_run = clean[4] && clean[6];
    wire logic if_alive = clean[5];
    wire logic rf_alive = clean[6];

    // ==============================
    // Shift register and latches
    logic [WORD_W-1:0] shift;
    logic [WORD_W-1:0] if_ref_latch;
    logic [WORD_W-1:0] if_prog_latch;
    logic [WORD_W-1:0] rf_ref_latch;
    logic [WORD_W-1:0] rf_prog_latch;

    // bit order follows the package setting
    wire logic [WORD_W-1:0] next_shift = MSB_FIRST ? {shift[WORD_W-2:0], sdata}
                                                   : {sdata, shift[WORD_W-1:1]};
    wire logic [1:0] ctrl = shift[CTRL_LSB +: CTRL_W];

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            shift <= LATCH_RST;
        // one bit per serial clock rise
        end else if (sclk_rise) begin
            shift <= next_shift;
        end
    end

    // level-sensitive load; supply loss clears the section
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            if_ref_latch <= LATCH_RST;
            if_prog_latch <= LATCH_RST;
            rf_ref_latch <= LATCH_RST;
            rf_prog_latch <= LATCH_RST;
        end else begin
            if (!if_alive) begin
                if_ref_latch <= LATCH_RST;
                if_prog_latch <= LATCH_RST;
            end else if (strobe) begin
                if (ctrl == CTRL_IF_REF) if_ref_latch <= shift;
                if (ctrl == CTRL_IF_PROG) if_prog_latch <= shift;
            end
            if (!rf_alive) begin
                rf_ref_latch <= LATCH_RST;
                rf_prog_latch <= LATCH_RST;
            end else if (strobe) begin
                if (ctrl == CTRL_RF_REF) rf_ref_latch <= shift;
                if (ctrl == CTRL_RF_PROG) rf_prog_latch <= shift;
            end
        end
    end

    // ==============================
    // Sections
    logic if_up;
    logic if_down;
    logic if_locked;
    logic if_ref_tick;
    logic if_mod;
    logic rf_up;
    logic rf_down;
    logic rf_locked;
    logic rf_ref_tick;
    logic rf_mod;

    dps_section #(.BASE_LO(IF_BASE_LO), .BASE_HI(IF_BASE_HI)) u_if (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(if_run),
        .ref_edge(rise[7]),
        .fin_edge(rise[8]),
        .ref_div(if_ref_latch[REF_LSB +: REF_W]),
        .swal_cnt(if_prog_latch[SWAL_LSB +: SWAL_W]),
        .main_cnt(if_prog_latch[MAIN_LSB +: MAIN_W]),
        .mod_sel(if_ref_latch[MODSEL_BIT]),
        .polarity(if_ref_latch[POL_BIT]),
        .pd_up(if_up),
        .pd_down(if_down),
        .locked(if_locked),
        .ref_tick(if_ref_tick),
        .modulus_ctrl(if_mod)
    );

    dps_section #(.BASE_LO(RF_BASE_LO), .BASE_HI(RF_BASE_HI)) u_rf (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(rf_run),
        .ref_edge(rise[7]),
        .fin_edge(rise[9]),
        .ref_div(rf_ref_latch[REF_LSB +: REF_W]),
        .swal_cnt(rf_prog_latch[SWAL_LSB +: SWAL_W]),
        .main_cnt(rf_prog_latch[MAIN_LSB +: MAIN_W]),
        .mod_sel(rf_ref_latch[MODSEL_BIT]),
        .polarity(rf_ref_latch[POL_BIT]),
        .pd_up(rf_up),
        .pd_down(rf_down),
        .locked(rf_locked),
        .ref_tick(rf_ref_tick),
        .modulus_ctrl(rf_mod)
    );

    // ==============================
    // Output pins
    // A stopped section does not hold the lock output low
    wire logic lock_detect_out = (if_locked || !if_run) && (rf_locked || !rf_run);
    logic monitor;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            monitor <= 1'b0;
            lock_or_monitor_out <= 1'b0;
            if_pump_up <= 1'b0;
            if_pump_down <= 1'b0;
            rf_pump_up <= 1'b0;
            rf_pump_down <= 1'b0;
            if_modulus_ctrl <= 1'b0;
            rf_modulus_ctrl <= 1'b0;
        end else begin
            monitor <= monitor ^ rf_ref_tick;
            lock_or_monitor_out <= rf_ref_latch[LOS_BIT] ? monitor : lock_detect_out;
            if_pump_up <= if_up;
            if_pump_down <= if_down;
            rf_pump_up <= rf_up;
            rf_pump_down <= rf_down;
            if_modulus_ctrl <= if_mod;
            rf_modulus_ctrl <= rf_mod;
        end
    end
endmodule // dps_top

`default_nettype wire

// >>> shared/dps_pkg.sv
package dps_pkg;
    // ==============================
    // Serial word
    localparam int WORD_W = 23;
    localparam int CTRL_LSB = 0;
    localparam int CTRL_W = 2;
    localparam logic [1:0] CTRL_IF_REF = 2'h0;
    localparam logic [1:0] CTRL_IF_PROG = 2'h1;
    localparam logic [1:0] CTRL_RF_REF = 2'h2;
    localparam logic [1:0] CTRL_RF_PROG = 2'h3;
    // 1: first bit shifted in ends up at the top of the word
    localparam bit MSB_FIRST = 1'b1;
    // ==============================
    // Reference latch fields
    localparam int REF_LSB = 2;
    localparam int REF_W = 14;
    localparam int MODSEL_BIT = 16;
    localparam int POL_BIT = 17;
    localparam int LOS_BIT = 18;
    // ==============================
    // Programmable latch fields
    localparam int SWAL_LSB = 2;
    localparam int SWAL_W = 7;
    localparam int MAIN_LSB = 9;
    localparam int MAIN_W = 11;
    // ==============================
    // Prescaler moduli (base values, the upper modulus is base + 1)
    localparam logic [7:0] IF_BASE_LO = 8'h10;
    localparam logic [7:0] IF_BASE_HI = 8'h20;
    localparam logic [7:0] RF_BASE_LO = 8'h40;
    localparam logic [7:0] RF_BASE_HI = 8'h80;
    // ==============================
    // Reset values and pin synchroniser
    localparam logic [WORD_W-1:0] LATCH_RST = 23'h000000;
    localparam int SYNC_W = 10;
    localparam int LOCK_HOLD = 4;
    localparam logic [2:0] LOCK_HOLD_CNT = 3'h4;
endpackage

// >>> verif/dps_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module dps_top_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Section controls
    input wire logic if_power_save_n,
    input wire logic rf_power_save_n,
    input wire logic if_supply_ok,
    input wire logic rf_supply_ok,
    // Outputs
    input wire logic if_pump_up,
    input wire logic if_pump_down,
    input wire logic rf_pump_up,
    input wire logic rf_pump_down,
    input wire logic if_modulus_ctrl,
    input wire logic rf_modulus_ctrl
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ==============================
    // Pumps never push both ways
    a_if_pump_excl: assert property (!(if_pump_up && if_pump_down))
        else $error("if pump up and down together");
    a_rf_pump_excl: assert property (!(rf_pump_up && rf_pump_down))
        else $error("rf pump up and down together");
    // ==============================
    // Seven cycles covers the pin filter, the section register and the output register
    a_if_save_quiet: assert property ((!if_power_save_n)[*7] |-> !if_pump_up && !if_pump_down && !if_modulus_ctrl)
        else $error("if section active in power saving");
    a_rf_save_quiet: assert property ((!rf_power_save_n)[*7] |-> !rf_pump_up && !rf_pump_down && !rf_modulus_ctrl)
        else $error("rf section active in power saving");
    a_if_supply_quiet: assert property ((!if_supply_ok)[*7] |-> !if_pump_up && !if_pump_down && !if_modulus_ctrl)
        else $error("if section active without supply");
    a_rf_supply_quiet: assert property ((!rf_supply_ok)[*7] |-> !rf_pump_up && !rf_pump_down && !rf_modulus_ctrl)
        else $error("rf section active without supply");
    // ==============================
    // One swallow step is at least seventeen slow input edges
    a_if_swallow_hold: assert property ($rose(if_modulus_ctrl) |=> if_modulus_ctrl[*8])
        else $error("if swallow phase too short");
    a_rf_swallow_hold: assert property ($rose(rf_modulus_ctrl) |=> rf_modulus_ctrl[*8])
        else $error("rf swallow phase too short");
endmodule // dps_top_props
`default_nettype wire

// >>> verif/dps_host.sv
`timescale 1ns/1ps
`default_nettype none
module dps_host (
    // Clock
    input wire logic clk_sys,
    // Serial link
    output logic serial_data,
    output logic serial_clock,
    output logic load_strobe
);
    import dps_pkg::*;
    initial begin
        serial_data = 1'b0;
        serial_clock = 1'b0;
        load_strobe = 1'b0;
    end
    // Five cycles per level, above the two the pin filter needs
    task automatic hold();
        repeat (5) @(negedge clk_sys);
    endtask
    // Three pins only, first bit lands at the top
    task automatic send(input logic [WORD_W-1:0] word);
        for (int i = WORD_W - 1; i >= 0; i--) begin
            serial_data = word[i];
            hold();
            serial_clock = 1'b1;
            hold();
            serial_clock = 1'b0;
        end
        hold();
        // Strobe only after shifting, clock held still
        load_strobe = 1'b1;
        hold();
        load_strobe = 1'b0;
        serial_data = ~serial_data;
        hold();
    endtask
endmodule // dps_host
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    import dps_pkg::*;
    typedef struct {bit rf; bit hi; int a; int n; int p;} dps_row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic serial_data, serial_clock, load_strobe;
    // Power-save inputs driven low from power-on
    logic if_power_save_n = 1'b0, rf_power_save_n = 1'b0;
    logic if_supply_ok = 1'b1, rf_supply_ok = 1'b1;
    logic ref_osc_in = 1'b0, if_prescaler_in = 1'b0, rf_prescaler_in = 1'b0;
    logic lock_or_monitor_out, if_pump_up, if_pump_down, rf_pump_up, rf_pump_down;
    logic if_modulus_ctrl, rf_modulus_ctrl;
    int mismatches = 0, comparisons = 0, div = 0;
    // Legal ratios with swallow below main
    dps_row_t rows [4] = '{'{0, 0, 1, 5, 16}, '{0, 1, 4, 5, 32}, '{1, 0, 4, 6, 64}, '{1, 1, 2, 5, 128}};
    dps_top i_dps_top (.*);
    dps_host i_dps_host (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    // Inputs stay well below a quarter of clk_sys
    always @(negedge clk_sys) begin
        div <= div + 1;
        if (div % 4 == 3) begin
            if_prescaler_in <= ~if_prescaler_in;
            rf_prescaler_in <= ~rf_prescaler_in;
        end
        if (div % 6 == 5) ref_osc_in <= ~ref_osc_in;
    end
    // ==============================
    // Serial words, R fixed at 5
    function automatic logic [22:0] ref_word(logic rf, logic hi, logic los);
        return {4'h0, los, 1'b0, hi, 14'h0005, rf, 1'b0};
    endfunction
    function automatic logic [22:0] prog_word(logic rf, logic [6:0] a, logic [10:0] n);
        return {3'h0, n, a, rf, 1'b1};
    endfunction
    // Input rises over one modulus period, skipping the first after a load
    task automatic measure(input logic rf, input int lim, output int per, output int hi);
        logic m, pm, ps;
        int rises;
        rises = 0;
        per = 0;
        hi = 0;
        pm = 1'b1;
        ps = 1'b0;
        repeat (lim) begin
            @(posedge clk_sys);
            #1;
            m = rf ? rf_modulus_ctrl : if_modulus_ctrl;
            if (m && !pm) rises++;
            if (rises == 3) break;
            if (rises == 2 && rf_prescaler_in && !ps) begin
                per++;
                hi += m;
            end
            pm = m;
            ps = rf_prescaler_in;
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        mismatches++;
        report_and_stop();
    end
    initial begin
        int per, hi, tog;
        logic prev;
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        repeat (6) @(negedge clk_sys);
        if_power_save_n = 1'b1;
        rf_power_save_n = 1'b1;
        foreach (rows[i]) begin
            i_dps_host.send(ref_word(rows[i].rf, rows[i].hi, 1'b0));
            i_dps_host.send(prog_word(rows[i].rf, rows[i].a, rows[i].n));
            measure(rows[i].rf, 30000, per, hi);
            `CHK("feedback period", rows[i].p * rows[i].n + rows[i].a, per)
            `CHK("swallow span", rows[i].a * (rows[i].p + 1), hi)
            $display("row %0d done", i);
        end
        i_dps_host.send(ref_word(1'b1, 1'b0, 1'b1));
        tog = 0;
        prev = lock_or_monitor_out;
        repeat (600) begin
            @(negedge clk_sys);
            tog += lock_or_monitor_out ^ prev;
            prev = lock_or_monitor_out;
        end
        `CHK("monitor toggles", 1'b1, tog > 4)
        i_dps_host.send(ref_word(1'b1, 1'b0, 1'b0));
        if_power_save_n = 1'b0;
        rf_power_save_n = 1'b0;
        repeat (100) @(negedge clk_sys);
        `CHK("lock detect", 1'b1, lock_or_monitor_out)
        $display("output select done");
        rf_power_save_n = 1'b1;
        rf_supply_ok = 1'b0;
        repeat (10) @(negedge clk_sys);
        rf_supply_ok = 1'b1;
        // Long enough for a stale word to complete two feedback periods
        measure(1'b1, 8000, per, hi);
        `CHK("period after supply loss", 0, per)
        $display("supply loss done");
        @(negedge clk_sys);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK("outputs in reset", 7'h00, {lock_or_monitor_out, if_pump_up, if_pump_down, rf_pump_up, rf_pump_down, if_modulus_ctrl, rf_modulus_ctrl})
        $display("reset done");
        report_and_stop();
    end
endmodule // tb_top
bind dps_top dps_top_props i_dps_top_props (.*);
`default_nettype wire
